// ==== src/lmf_pkg.sv ====
// Constants and types for the LED matrix function-register bank
// Operation
// - Phase bit D7: 0 no delay, 1 gives 180 degree PWM phase delay.
// - Row pull-down field D6:D4, default 011, eight resistor codes.
// - Column pull-up field D2:D0, default 011, same encoding as row field.
// - Twelve result registers read-only, six flags in D5:D0, upper bits zero.
// - Detect field written 01 launches one open pass, flags stored; code launches only when the field was 00 and no pass runs.
// - Detect field written 10 launches one short pass, flags stored; code launches only when the field was 00 and no pass runs.
// - Roll-off percentage D1:D0: 100, 75, 55, 30 percent.
// - Threshold D3:D2: 140, 120, 100, 90 degrees Celsius.
// - At threshold enter roll-off and reduce current to programmed percentage.
// - Spread enable D4 turns spreading on; range and cycle apply only then.
// - Spread range D3:D2: 5, 15, 24, 34 percent deviation.
// - Spread cycle D1:D0: 1980, 1200, 820, 660 microseconds.
// - Writing 0xae to 8Fh returns every register to default.
// - Power-up reset gives default values, display blank.
// - Rate at E2h applies only while unlock bit D0 of E0h is 1.
// - Rate code D7:D5 selects 29 kHz halving down to 453 Hz.
// - Detect field is config bits D2:D1; 00 off, 01/11 open, 10 short.
package lmf_pkg;
    localparam logic [7:0] ADDR_CONFIG   = 8'h50;
    localparam logic [7:0] ADDR_CURRENT  = 8'h51;
    localparam logic [7:0] ADDR_PULL     = 8'h52;
    localparam logic [7:0] ADDR_RES_LO   = 8'h53;
    localparam logic [7:0] ADDR_RES_HI   = 8'h5e;
    localparam logic [7:0] ADDR_THERM    = 8'h5f;
    localparam logic [7:0] ADDR_SPREAD   = 8'h60;
    localparam logic [7:0] ADDR_RESET    = 8'h8f;
    localparam logic [7:0] ADDR_UNLOCK   = 8'he0;
    localparam logic [7:0] ADDR_RATE     = 8'he2;
    localparam logic [7:0] RESET_MAGIC   = 8'hae;
    localparam logic [7:0] RST_PULL      = 8'h33;
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam logic [7:0] MASK_PULL     = 8'hf7;
    localparam logic [7:0] MASK_RESULT   = 8'h3f;
    localparam logic [7:0] MASK_THERM    = 8'h0f;
    localparam logic [7:0] MASK_SPREAD   = 8'h1f;
    localparam logic [7:0] MASK_UNLOCK   = 8'h01;
    localparam logic [7:0] MASK_RATE     = 8'he0;
    localparam logic [7:0] MASK_CONFIG   = 8'hf7;
    localparam int         RESULT_NUM    = 12;
    localparam int         PHASE_BIT     = 7;
    localparam int         ROW_LSB       = 4;
    localparam int         DET_LSB       = 1;
    localparam int         SPREAD_EN_BIT = 4;
    localparam int         RATE_LSB      = 5;
    localparam logic [2:0] RATE_DEFAULT  = 3'h0;
    localparam logic [1:0] DET_OFF       = 2'h0;
    localparam logic [1:0] DET_SHORT     = 2'h2;
    // Detection pass length, in microseconds and in cycles
    localparam int          DET_TIME_US  = 10;
    localparam int          CLK_MHZ      = 20;
    localparam logic [15:0] DET_CYCLES   = 16'(DET_TIME_US * CLK_MHZ);
    // Thermal thresholds, degrees Celsius
    localparam logic [7:0] THR_C0 = 8'd140;
    localparam logic [7:0] THR_C1 = 8'd120;
    localparam logic [7:0] THR_C2 = 8'd100;
    localparam logic [7:0] THR_C3 = 8'd90;
    // Current scale in percent
    localparam logic [6:0] PCT_0 = 7'd100;
    localparam logic [6:0] PCT_1 = 7'd75;
    localparam logic [6:0] PCT_2 = 7'd55;
    localparam logic [6:0] PCT_3 = 7'd30;
    typedef enum logic [1:0] {
        LMF_IDLE = 2'b00,
        LMF_RUN  = 2'b01,
        LMF_DONE = 2'b11
    } lmf_det_t;

    function automatic logic [7:0] lmf_threshold(input logic [1:0] code);
        unique case (code)
            2'h0: lmf_threshold = THR_C0;
            2'h1: lmf_threshold = THR_C1;
            2'h2: lmf_threshold = THR_C2;
            2'h3: lmf_threshold = THR_C3;
        endcase
    endfunction

    function automatic logic [6:0] lmf_percent(input logic [1:0] code);
        unique case (code)
            2'h0: lmf_percent = PCT_0;
            2'h1: lmf_percent = PCT_1;
            2'h2: lmf_percent = PCT_2;
            2'h3: lmf_percent = PCT_3;
        endcase
    endfunction
endpackage

// ==== src/lmf_result_mem.sv ====
// Open/short result store: twelve six-bit words, registered read
`timescale 1ns/1ps
`default_nettype none
module lmf_result_mem
    import lmf_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       ce,
    input  wire logic       clr,
    input  wire logic       wr_en,
    input  wire logic [3:0] wr_idx,
    input  wire logic [5:0] wr_data,
    input  wire logic [3:0] rd_idx,
    output logic      [5:0] rd_data_ff
);
    logic [5:0] mem_ff [RESULT_NUM];

    always_ff @(posedge sys_clk) begin
        if (srst || (ce && clr)) begin
            for (int i = 0; i < RESULT_NUM; i++) begin
                mem_ff[i] <= 6'h00;
            end
        end else if (ce && wr_en) begin
            mem_ff[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_data_ff <= 6'h00;
        end else if (ce) begin
            rd_data_ff <= (rd_idx < 4'(RESULT_NUM)) ? mem_ff[rd_idx] : 6'h00;
        end
    end
endmodule
`default_nettype wire

// ==== src/lmf_detect.sv ====
// Open/short detection sequencer: one pass per launch
`timescale 1ns/1ps
`default_nettype none
module lmf_detect
    import lmf_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic        start,
    input  wire logic [71:0] fault_in,
    output logic             busy_ff,
    output logic             wr_en_ff,
    output logic       [3:0] wr_idx_ff,
    output logic       [5:0] wr_data_ff
);
    lmf_det_t    st_ff;
    logic [15:0] cnt_ff;

    // Flags sampled word by word after the settle time, written one word per cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_ff      <= LMF_IDLE;
            cnt_ff     <= 16'h0000;
            busy_ff    <= 1'b0;
            wr_en_ff   <= 1'b0;
            wr_idx_ff  <= 4'h0;
            wr_data_ff <= 6'h00;
        end else if (ce) begin
            wr_en_ff <= 1'b0;
            unique case (st_ff)
                LMF_IDLE: begin
                    if (start) begin
                        st_ff   <= LMF_RUN;
                        cnt_ff  <= 16'h0000;
                        busy_ff <= 1'b1;
                    end
                end
                LMF_RUN: begin
                    if (cnt_ff == DET_CYCLES - 16'h0001) begin
                        st_ff     <= LMF_DONE;
                        cnt_ff    <= 16'h0000;
                    end else begin
                        cnt_ff <= cnt_ff + 16'h0001;
                    end
                end
                LMF_DONE: begin
                    wr_en_ff   <= 1'b1;
                    wr_idx_ff  <= cnt_ff[3:0];
                    wr_data_ff <= fault_in[cnt_ff[3:0]*6 +: 6];
                    if (cnt_ff == 16'(RESULT_NUM - 1)) begin
                        st_ff   <= LMF_IDLE;
                        busy_ff <= 1'b0;
                    end else begin
                        cnt_ff <= cnt_ff + 16'h0001;
                    end
                end
                default: st_ff <= LMF_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== src/lmf_regs.sv ====
// Function-register bank of the LED matrix driver, page 1
`timescale 1ns/1ps
`default_nettype none
module lmf_regs
    import lmf_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic [7:0]  die_temp,
    input  wire logic [71:0] open_flags,
    input  wire logic [71:0] short_flags,
    output logic      [7:0]  rdata_ff,
    output logic             phase_choice_ff,
    output logic      [2:0]  row_pulldown_select_ff,
    output logic      [2:0]  column_pullup_select_ff,
    output logic             rolloff_active_ff,
    output logic      [6:0]  current_pct_ff,
    output logic             spread_enable_ff,
    output logic      [1:0]  spread_range_ff,
    output logic      [1:0]  spread_cycle_time_ff,
    output logic      [2:0]  pwm_rate_code_ff,
    output logic      [7:0]  global_current_value_ff,
    output logic             detect_busy_ff
);
    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [7:0] config_ff;
    logic [7:0] pull_ff;
    logic [7:0] therm_ff;
    logic [7:0] spread_ff;
    logic [7:0] unlock_ff;
    logic [7:0] rate_ff;
    logic       soft_rst_ff;
    logic       det_start;
    logic       det_short_ff;
    logic       det_busy;
    logic       res_wr;
    logic [3:0] res_idx;
    logic [5:0] res_data;
    logic [5:0] res_rd;
    logic [3:0] rd_idx;
    logic       rd_res_ff;
    logic [7:0] rd_other_ff;
    logic [1:0] det_field;
    logic [1:0] nxt_det_field;
    logic       cfg_wr;

    assign cfg_wr        = wr_stb && addr == ADDR_CONFIG;
    assign det_field     = config_ff[DET_LSB +: 2];
    assign nxt_det_field = wdata[DET_LSB +: 2];
    // Launch only on a move from off to a detect code
    assign det_start     = ce && cfg_wr && det_field == DET_OFF
                           && nxt_det_field != DET_OFF && !det_busy;
    assign rd_idx        = 4'(addr - ADDR_RES_LO);

    // Magic write resets the registers, detection and result store on the following edge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            soft_rst_ff <= 1'b0;
        end else if (ce) begin
            soft_rst_ff <= wr_stb && addr == ADDR_RESET && wdata == RESET_MAGIC;
        end
    end

    // Writable registers; reserved bits masked off
    always_ff @(posedge sys_clk) begin
        if (srst || soft_rst_ff) begin
            config_ff <= RST_ZERO;
            global_current_value_ff <= RST_ZERO;
            pull_ff   <= RST_PULL;
            therm_ff  <= RST_ZERO;
            spread_ff <= RST_ZERO;
            unlock_ff <= RST_ZERO;
            rate_ff   <= RST_ZERO;
        end else if (ce && wr_stb) begin
            unique case (addr)
                ADDR_CONFIG: config_ff <= wdata & MASK_CONFIG;
                ADDR_CURRENT: global_current_value_ff <= wdata;
                ADDR_PULL:   pull_ff   <= wdata & MASK_PULL;
                ADDR_THERM:  therm_ff  <= wdata & MASK_THERM;
                ADDR_SPREAD: spread_ff <= wdata & MASK_SPREAD;
                ADDR_UNLOCK: unlock_ff <= wdata & MASK_UNLOCK;
                ADDR_RATE:   rate_ff   <= wdata & MASK_RATE;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Detection
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst || soft_rst_ff) begin
            det_short_ff <= 1'b0;
        end else if (det_start) begin
            det_short_ff <= nxt_det_field == DET_SHORT;
        end
    end

    lmf_detect lmf_detect_inst (
        .sys_clk    (sys_clk),
        .srst       (srst || soft_rst_ff),
        .ce         (ce),
        .start      (det_start),
        .fault_in   (det_short_ff ? short_flags : open_flags),
        .busy_ff    (det_busy),
        .wr_en_ff   (res_wr),
        .wr_idx_ff  (res_idx),
        .wr_data_ff (res_data)
    );

    lmf_result_mem lmf_result_mem_inst (
        .sys_clk    (sys_clk),
        .srst       (srst),
        .ce         (ce),
        .clr        (soft_rst_ff),
        .wr_en      (res_wr),
        .wr_idx     (res_idx),
        .wr_data    (res_data),
        .rd_idx     (rd_idx),
        .rd_data_ff (res_rd)
    );

    // ----------------------------------------------------------------
    // Read path: two cycles from strobe to data
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_res_ff   <= 1'b0;
            rd_other_ff <= 8'h00;
        end else if (ce) begin
            rd_res_ff <= rd_stb && addr >= ADDR_RES_LO && addr <= ADDR_RES_HI;
            unique case (addr)
                ADDR_CONFIG: rd_other_ff <= config_ff;
                ADDR_CURRENT: rd_other_ff <= global_current_value_ff;
                ADDR_PULL:   rd_other_ff <= pull_ff;
                ADDR_THERM:  rd_other_ff <= therm_ff;
                ADDR_SPREAD: rd_other_ff <= spread_ff;
                ADDR_UNLOCK: rd_other_ff <= unlock_ff;
                ADDR_RATE:   rd_other_ff <= rate_ff;
                default:     rd_other_ff <= 8'h00;
            endcase
        end
    end

    // Mux after the registered memory read; result words read zero above D5
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_ff <= 8'h00;
        end else if (ce) begin
            rdata_ff <= rd_res_ff ? {2'b00, res_rd} : rd_other_ff;
        end
    end

    // ----------------------------------------------------------------
    // Decoded controls
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            phase_choice_ff         <= 1'b0;
            row_pulldown_select_ff  <= RST_PULL[ROW_LSB +: 3];
            column_pullup_select_ff <= RST_PULL[2:0];
        end else if (ce) begin
            phase_choice_ff         <= pull_ff[PHASE_BIT];
            row_pulldown_select_ff  <= pull_ff[ROW_LSB +: 3];
            column_pullup_select_ff <= pull_ff[2:0];
        end
    end

    // Roll-off follows die temperature against the chosen threshold
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rolloff_active_ff <= 1'b0;
            current_pct_ff    <= PCT_0;
        end else if (ce) begin
            rolloff_active_ff <= die_temp >= lmf_threshold(therm_ff[3:2]);
            current_pct_ff    <= (die_temp >= lmf_threshold(therm_ff[3:2]))
                                 ? lmf_percent(therm_ff[1:0]) : PCT_0;
        end
    end

    // Range and cycle are forced to zero while spreading is off
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            spread_enable_ff     <= 1'b0;
            spread_range_ff      <= 2'h0;
            spread_cycle_time_ff <= 2'h0;
        end else if (ce) begin
            spread_enable_ff     <= spread_ff[SPREAD_EN_BIT];
            spread_range_ff      <= spread_ff[SPREAD_EN_BIT] ? spread_ff[3:2] : 2'h0;
            spread_cycle_time_ff <= spread_ff[SPREAD_EN_BIT] ? spread_ff[1:0] : 2'h0;
        end
    end

    // Code 111 is the same rate as 000; downstream maps both to the top rate
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pwm_rate_code_ff <= RATE_DEFAULT;
            detect_busy_ff   <= 1'b0;
        end else if (ce) begin
            pwm_rate_code_ff <= unlock_ff[0] ? rate_ff[RATE_LSB +: 3]
                                             : RATE_DEFAULT;
            detect_busy_ff   <= det_busy;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_rate_locked;
        @(posedge sys_clk) disable iff (srst)
        ce && !unlock_ff[0] |=> pwm_rate_code_ff == RATE_DEFAULT;
    endproperty
    a_rate_locked: assert property (p_rate_locked) else $error("rate moved while locked");

    property p_soft_reset;
        @(posedge sys_clk) disable iff (srst)
        ce && wr_stb && addr == ADDR_RESET && wdata == RESET_MAGIC
            |=> ##1 pull_ff == RST_PULL && rate_ff == RST_ZERO;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("magic write no reset");

    property p_result_upper;
        @(posedge sys_clk) disable iff (srst)
        rd_res_ff && ce |=> rdata_ff[7:6] == 2'b00;
    endproperty
    a_result_upper: assert property (p_result_upper) else $error("result upper bits set");

    property p_reserved_zero;
        @(posedge sys_clk) disable iff (srst)
        (pull_ff[3] == 1'b0) && (therm_ff[7:4] == 4'h0) && (rate_ff[4:0] == 5'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_spread_off;
        @(posedge sys_clk) disable iff (srst)
        ce && !spread_ff[SPREAD_EN_BIT] |=> spread_range_ff == 2'h0 && !spread_enable_ff;
    endproperty
    a_spread_off: assert property (p_spread_off) else $error("spread active when off");

    property p_phase;
        @(posedge sys_clk) disable iff (srst)
        ce |=> phase_choice_ff == $past(pull_ff[PHASE_BIT]);
    endproperty
    a_phase: assert property (p_phase) else $error("phase bit not followed");

    property p_rolloff_pct;
        @(posedge sys_clk) disable iff (srst)
        rolloff_active_ff && therm_ff[1:0] == 2'h3 && $stable(therm_ff) |-> current_pct_ff == PCT_3;
    endproperty
    a_rolloff_pct: assert property (p_rolloff_pct) else $error("rolloff pct wrong");

    property p_det_launch;
        @(posedge sys_clk) disable iff (srst || soft_rst_ff)
        det_start |=> ##[1:2] det_busy;
    endproperty
    a_det_launch: assert property (p_det_launch) else $error("detection not launched");

    property p_cool;
        @(posedge sys_clk) disable iff (srst)
        ce && die_temp < lmf_threshold(therm_ff[3:2]) |=> !rolloff_active_ff;
    endproperty
    a_cool: assert property (p_cool) else $error("rolloff below threshold");

    property p_row_sel;
        @(posedge sys_clk) disable iff (srst)
        ce |=> row_pulldown_select_ff == $past(pull_ff[ROW_LSB +: 3]);
    endproperty
    a_row_sel: assert property (p_row_sel) else $error("row select not followed");

    property p_col_sel;
        @(posedge sys_clk) disable iff (srst)
        ce |=> column_pullup_select_ff == $past(pull_ff[2:0]);
    endproperty
    a_col_sel: assert property (p_col_sel) else $error("column select not followed");

    property p_rate_open;
        @(posedge sys_clk) disable iff (srst)
        ce && unlock_ff[0] |=> pwm_rate_code_ff == $past(rate_ff[RATE_LSB +: 3]);
    endproperty
    a_rate_open: assert property (p_rate_open) else $error("rate code not applied");

    property p_spread_on;
        @(posedge sys_clk) disable iff (srst)
        ce && spread_ff[SPREAD_EN_BIT] |=> spread_enable_ff
            && spread_range_ff == $past(spread_ff[3:2])
            && spread_cycle_time_ff == $past(spread_ff[1:0]);
    endproperty
    a_spread_on: assert property (p_spread_on) else $error("spread fields not applied");

    property p_det_open;
        @(posedge sys_clk) disable iff (srst || soft_rst_ff)
        det_start && nxt_det_field != DET_SHORT |=> !det_short_ff;
    endproperty
    a_det_open: assert property (p_det_open) else $error("open pass took short flags");

    property p_det_short;
        @(posedge sys_clk) disable iff (srst || soft_rst_ff)
        det_start && nxt_det_field == DET_SHORT |=> det_short_ff;
    endproperty
    a_det_short: assert property (p_det_short) else $error("short pass took open flags");

    property p_hot;
        @(posedge sys_clk) disable iff (srst)
        ce && die_temp >= lmf_threshold(therm_ff[3:2]) |=> rolloff_active_ff;
    endproperty
    a_hot: assert property (p_hot) else $error("no rolloff at threshold");
endmodule
`default_nettype wire

// ==== bench/lmf_host_model.sv ====
// Host bus master model: register write, read and detection launch cycles
`timescale 1ns/1ps
`default_nettype none
module lmf_host_model
    import lmf_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic [7:0] rdata_ff,
    output var  logic       wr_stb,
    output var  logic       rd_stb,
    output var  logic [7:0] addr,
    output var  logic [7:0] wdata
);
    initial begin
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        addr   = 8'h00;
        wdata  = 8'h00;
    end

    // Function page is taken as already selected, so addresses are page-1 offsets
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        addr   = a;
        wdata  = d;
        wr_stb = 1'b1;
        @(posedge sys_clk);
        #1;
        wr_stb = 1'b0;
        // Released lines show the inverse so a stale value never passes
        addr   = ~a;
        wdata  = ~d;
    endtask

    // Result words stand one cycle only, so data is taken two edges after the strobe
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1;
        addr   = a;
        rd_stb = 1'b1;
        @(posedge sys_clk);
        #1;
        rd_stb = 1'b0;
        @(posedge sys_clk);
        #1;
        d      = rdata_ff;
        addr   = ~a;
    endtask

    task automatic launch(input logic [1:0] code);
        write(ADDR_CURRENT, 8'h01);
        write(ADDR_CONFIG, 8'h00);
        write(ADDR_CONFIG, {5'h00, code, 1'b0});
    endtask
endmodule
`default_nettype wire

// ==== bench/lmf_regs_tb.sv ====
// Self-checking testbench of the function-register bank
`timescale 1ns/1ps
`default_nettype none
module lmf_regs_tb;
    import lmf_pkg::*;
    logic        sys_clk, srst, ce, wr_stb, rd_stb, rolloff_active_ff, phase_choice_ff;
    logic        spread_enable_ff, detect_busy_ff;
    logic [7:0]  addr, wdata, die_temp, rdata_ff, global_current_value_ff;
    logic [71:0] open_flags, short_flags;
    logic [2:0]  row_pulldown_select_ff, column_pullup_select_ff, pwm_rate_code_ff;
    logic [1:0]  spread_range_ff, spread_cycle_time_ff;
    logic [6:0]  current_pct_ff;
    logic [7:0]  thr [4];
    logic [7:0]  pct [4];
    int          n_mismatch;
    int          compares;
    int          i;

    lmf_regs lmf_regs_inst (.sys_clk(sys_clk), .srst(srst), .ce(ce), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .addr(addr), .wdata(wdata), .die_temp(die_temp),
        .open_flags(open_flags), .short_flags(short_flags), .rdata_ff(rdata_ff),
        .phase_choice_ff(phase_choice_ff), .row_pulldown_select_ff(row_pulldown_select_ff),
        .column_pullup_select_ff(column_pullup_select_ff),
        .rolloff_active_ff(rolloff_active_ff), .current_pct_ff(current_pct_ff),
        .spread_enable_ff(spread_enable_ff), .spread_range_ff(spread_range_ff),
        .spread_cycle_time_ff(spread_cycle_time_ff), .pwm_rate_code_ff(pwm_rate_code_ff),
        .global_current_value_ff(global_current_value_ff), .detect_busy_ff(detect_busy_ff));

    lmf_host_model lmf_host_model_inst (.sys_clk(sys_clk), .rdata_ff(rdata_ff),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .addr(addr), .wdata(wdata));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Access and comparison tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        lmf_host_model_inst.write(a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        lmf_host_model_inst.read(a, v);
        check(v, exp);
    endtask

    // Bounded wait for a whole pass: busy must rise, then fall
    task automatic wait_pass();
        int k;
        for (k = 0; k < 20 && detect_busy_ff !== 1'b1; k++) tick(1);
        if (detect_busy_ff !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
        end
        for (k = 0; k < 400 && detect_busy_ff !== 1'b0; k++) tick(1);
        if (detect_busy_ff !== 1'b0) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask

    task automatic rd_results(input logic [71:0] f);
        int k;
        for (k = 0; k < 12; k++) rd_chk(ADDR_RES_LO + 8'(k), {2'b00, f[6*k +: 6]});
    endtask

    task automatic defaults();
        logic [7:0] za [8];
        int k;
        za = '{ADDR_CONFIG, ADDR_CURRENT, ADDR_THERM, ADDR_SPREAD, ADDR_RESET, ADDR_UNLOCK,
               ADDR_RATE, 8'h70};
        for (k = 0; k < 8; k++) rd_chk(za[k], 8'h00);
        rd_chk(ADDR_PULL, 8'h33);
        rd_results(72'h0);
        check({phase_choice_ff, row_pulldown_select_ff, 1'b0, column_pullup_select_ff}, 8'h33);
        check(8'(current_pct_ff), 8'h64);
        check({spread_enable_ff, spread_range_ff, spread_cycle_time_ff, pwm_rate_code_ff}, 8'h00);
        check({6'h00, rolloff_active_ff, detect_busy_ff}, 8'h00);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        n_mismatch  = 0;
        compares    = 0;
        srst        = 1'b1;
        ce          = 1'b1;
        die_temp    = 8'h00;
        open_flags  = 72'h123456789abcdef0a5;
        short_flags = 72'h5a0fedcba987654321;
        thr = '{8'h8c, 8'h78, 8'h64, 8'h5a};
        pct = '{8'h64, 8'h4b, 8'h37, 8'h1e};
        repeat (2) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        defaults();
        for (i = 0; i < 8; i++) begin
            wr(ADDR_PULL, {i[0], 3'(i), 1'b1, 3'(7 - i)});
            tick(1);
            check({phase_choice_ff, row_pulldown_select_ff}, {4'h0, i[0], 3'(i)});
            check(8'(column_pullup_select_ff), 8'(7 - i));
            rd_chk(ADDR_PULL, {i[0], 3'(i), 1'b0, 3'(7 - i)});
        end
        for (i = 0; i < 4; i++) begin
            wr(ADDR_THERM, {4'hf, 2'(i), 2'(3 - i)});
            rd_chk(ADDR_THERM, {4'h0, 2'(i), 2'(3 - i)});
            die_temp = thr[i] - 8'h01;
            tick(3);
            check({rolloff_active_ff, current_pct_ff}, 8'h64);
            die_temp = thr[i];
            tick(3);
            check({rolloff_active_ff, current_pct_ff}, {1'b1, pct[3 - i][6:0]});
        end
        die_temp = 8'h00;
        wr(ADDR_SPREAD, 8'hef);
        rd_chk(ADDR_SPREAD, 8'h0f);
        check({spread_enable_ff, spread_range_ff, spread_cycle_time_ff}, 8'h00);
        for (i = 0; i < 4; i++) begin
            wr(ADDR_SPREAD, {3'h7, 1'b1, 2'(i), 2'(3 - i)});
            tick(1);
            check({spread_enable_ff, spread_range_ff, spread_cycle_time_ff},
                  {3'h0, 1'b1, 2'(i), 2'(3 - i)});
        end
        wr(ADDR_RATE, 8'hdf);
        rd_chk(ADDR_RATE, 8'hc0);
        check(8'(pwm_rate_code_ff), 8'h00);
        wr(ADDR_UNLOCK, 8'hff);
        rd_chk(ADDR_UNLOCK, 8'h01);
        check(8'(pwm_rate_code_ff), 8'h06);
        for (i = 0; i < 8; i++) begin
            wr(ADDR_RATE, {3'(i), 5'h1f});
            tick(1);
            check(8'(pwm_rate_code_ff), 8'(i));
        end
        wr(ADDR_UNLOCK, 8'h00);
        tick(1);
        check(8'(pwm_rate_code_ff), 8'h00);
        lmf_host_model_inst.launch(2'h1);
        check(global_current_value_ff, 8'h01);
        wait_pass();
        rd_results(open_flags);
        wr(ADDR_CONFIG, 8'h04);
        tick(10);
        check(8'(detect_busy_ff), 8'h00);
        rd_chk(ADDR_CONFIG, 8'h04);
        wr(ADDR_RES_LO, 8'hff);
        rd_results(open_flags);
        lmf_host_model_inst.launch(2'h2);
        wait_pass();
        rd_results(short_flags);
        lmf_host_model_inst.launch(2'h3);
        wait_pass();
        rd_results(open_flags);
        wr(ADDR_RESET, 8'h12);
        rd_chk(ADDR_PULL, 8'hf0);
        ce = 1'b0;
        wr(ADDR_PULL, 8'h00);
        ce = 1'b1;
        rd_chk(ADDR_PULL, 8'hf0);
        check(8'(row_pulldown_select_ff), 8'h07);
        wr(ADDR_RESET, RESET_MAGIC);
        tick(2);
        defaults();
        wr(ADDR_THERM, 8'h0f);
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        defaults();
        report_and_stop();
    end
endmodule
`default_nettype wire
